// >>> src/sleep_retention_pkg.sv
// Constants, register map and default tables for the sleep retention register bank
package sleep_retention_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int          NUM_RESOURCES   = 14;     // Ten regulators, four bucks
    localparam int          REG_W           = 8;      // Width of each retention register
    localparam int          AXI_ADDR_W      = 8;      // Byte address width of the slave
    localparam int          AXI_DATA_W      = 32;     // Data width of the slave
    localparam int          VARIANT_W       = 2;      // Width of factory variant select

    // ------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0]  IDX_RETAIN_LOW  = 8'h27;  // Regulators one to eight
    localparam logic [7:0]  IDX_RETAIN_HIGH = 8'h28;  // Regulators nine, ten and bucks
    localparam logic [7:0]  IDX_STATUS      = 8'h30;  // Live sleep state, read only

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam logic [7:0]  HIGH_WRITE_MASK = 8'h3F;  // Bits 7 and 6 reserved, read as zero
    localparam int          STATUS_ASLEEP   = 0;      // Status bit: sleep state active

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY       = 2'h0;   // Access done
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;   // Unmapped address

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Byte address of a register index
    function automatic logic [AXI_ADDR_W-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = {idx[5:0], 2'b00};
    endfunction : byte_addr

    // Factory default of the low retention register per programmed variant
    function automatic logic [REG_W-1:0] default_low(input logic [VARIANT_W-1:0] v);
        case (v)
            2'h0:    default_low = 8'hE6;
            2'h1:    default_low = 8'hE6;
            2'h2:    default_low = 8'h1A;
            default: default_low = 8'hFA;
        endcase
    endfunction : default_low

    // Factory default of the high retention register per programmed variant
    function automatic logic [REG_W-1:0] default_high(input logic [VARIANT_W-1:0] v);
        case (v)
            2'h0:    default_high = 8'h3B;
            2'h1:    default_high = 8'h3B;
            2'h2:    default_high = 8'h12;
            default: default_high = 8'h1F;
        endcase
    endfunction : default_high

endpackage : sleep_retention_pkg

// >>> src/sleep_mode_if.sv
// Interface between the register bank and the per-resource sleep mode decoder
`timescale 1ns/1ps
interface sleep_mode_if;
    import sleep_retention_pkg::*;

    logic [NUM_RESOURCES-1:0] retain;   // Stay fully active in sleep
    logic [NUM_RESOURCES-1:0] turnoff;  // Switch off in sleep unless retained
    logic                     asleep;   // Sleep state in force
    logic [NUM_RESOURCES-1:0] economy_low_power_mode;      // Resource wanted in economy mode
    logic [NUM_RESOURCES-1:0] off;      // Resource wanted switched off

    modport ctrl   (output retain, output turnoff, output asleep, input economy_low_power_mode, input off);
    modport decode (input retain, input turnoff, input asleep, output economy_low_power_mode, output off);
endinterface : sleep_mode_if

// >>> src/sleep_mode_decoder.sv
// Per-resource decode of sleep behaviour from retention and turn-off bits
`timescale 1ns/1ps
module sleep_mode_decoder
    import sleep_retention_pkg::*;
(
    sleep_mode_if.decode modes  // Retention, turn-off and sleep in; modes out
);

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    // Outside sleep every resource stays active; the retained bit always wins
    always_comb begin
        for (int i = 0; i < NUM_RESOURCES; i++) begin
            if (!modes.asleep || modes.retain[i]) begin
                modes.economy_low_power_mode[i] = 1'b0;
                modes.off[i] = 1'b0;
            end else if (modes.turnoff[i]) begin
                modes.economy_low_power_mode[i] = 1'b0;
                modes.off[i] = 1'b1;
            end else begin
                modes.economy_low_power_mode[i] = 1'b1;
                modes.off[i] = 1'b0;
            end
        end
    end

endmodule : sleep_mode_decoder

// >>> src/sleep_retention_control_regs.sv
// Sleep retention register bank with AXI4-Lite slave and sleep mode outputs
// Strap is read only in reset
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module sleep_retention_control_regs
    import sleep_retention_pkg::*;
(
    input  wire logic                     aclk,           // 25 MHz clock
    input  wire logic                     aresetn,        // Power-on reset, sync, low
    input  wire logic [VARIANT_W-1:0]     otp_variant,    // Factory programmed variant
    input  wire logic                     sleep_req,      // Sleep pin, asynchronous
    input  wire logic [NUM_RESOURCES-1:0] sleep_turnoff,  // Turn-off bits from own logic
    input  wire logic [AXI_ADDR_W-1:0]    s_axi_awaddr,   // Write address
    input  wire logic [2:0]               s_axi_awprot,   // Write protection, unused
    input  wire logic                     s_axi_awvalid,  // Write address valid
    output logic                          s_axi_awready,  // Write address ready
    input  wire logic [AXI_DATA_W-1:0]    s_axi_wdata,    // Write data
    input  wire logic [3:0]               s_axi_wstrb,    // Write byte strobes
    input  wire logic                     s_axi_wvalid,   // Write data valid
    output logic                          s_axi_wready,   // Write data ready
    output logic [1:0]                    s_axi_bresp,    // Write response code
    output logic                          s_axi_bvalid,   // Write response valid
    input  wire logic                     s_axi_bready,   // Write response ready
    input  wire logic [AXI_ADDR_W-1:0]    s_axi_araddr,   // Read address
    input  wire logic [2:0]               s_axi_arprot,   // Read protection, unused
    input  wire logic                     s_axi_arvalid,  // Read address valid
    output logic                          s_axi_arready,  // Read address ready
    output logic [AXI_DATA_W-1:0]         s_axi_rdata,    // Read data
    output logic [1:0]                    s_axi_rresp,    // Read response code
    output logic                          s_axi_rvalid,   // Read data valid
    input  wire logic                     s_axi_rready,   // Read data ready
    output logic [NUM_RESOURCES-1:0]      res_eco,        // Resource in economy mode
    output logic [NUM_RESOURCES-1:0]      res_off         // Resource switched off
);

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    // One write at a time
    typedef enum logic [1:0] {
        WR_ACCEPT = 2'b01,  // Collecting address and data
        WR_RESP   = 2'b10   // Holding the write response
    } wr_state_t;

    // One read at a time
    typedef enum logic [1:0] {
        RD_ACCEPT = 2'b01,  // Waiting for a read address
        RD_RESP   = 2'b10   // Holding the read data
    } rd_state_t;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [VARIANT_W-1:0]  otp_meta;        // Variant, first synchroniser stage
    logic [VARIANT_W-1:0]  otp_sync;        // Variant, second synchroniser stage
    logic                  sleep_meta;      // Sleep pin, first synchroniser stage
    logic                  sleep_sync;      // Sleep pin, second synchroniser stage

    // Retention storage
    logic [REG_W-1:0]      sleep_retain_ldo_low;                 // Regulators one to eight
    logic [REG_W-1:0]      sleep_retain_ldo_high_and_converters; // Nine, ten, bucks

    // Channel states
    wr_state_t             wr_state;        // Write channel state
    rd_state_t             rd_state;        // Read channel state

    // Write bookkeeping
    logic                  aw_held;         // Write address captured early
    logic                  w_held;          // Write data captured early
    logic [AXI_ADDR_W-1:0] awaddr_q;        // Captured write address
    logic [AXI_DATA_W-1:0] wdata_q;         // Captured write data
    logic [3:0]            wstrb_q;         // Captured write strobes

    // Write decode
    logic                  aw_fire;         // Address handshake this cycle
    logic                  w_fire;          // Data handshake this cycle
    logic                  do_write;        // Both halves present, commit now
    logic [AXI_ADDR_W-1:0] wr_addr;         // Effective write address
    logic [AXI_DATA_W-1:0] wr_data;         // Effective write data
    logic [3:0]            wr_strb;         // Effective write strobes
    logic                  wr_hit_low;      // Write targets low register
    logic                  wr_hit_high;     // Write targets high register
    logic                  wr_hit_stat;     // Write targets status register

    // Read path
    logic                  ar_fire;         // Read address handshake
    logic [AXI_DATA_W-1:0] next_rdata;      // Read data for the address taken
    logic [1:0]            next_rresp;      // Read answer for the address taken

    sleep_mode_if modes ();                 // Link to the mode decoder

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // The variant straps and sleep pin come from outside the clock domain
    // A static strap needs no gray code
    always_ff @(posedge aclk) begin
        otp_meta   <= otp_variant;
        otp_sync   <= otp_meta;
        sleep_meta <= sleep_req;
        sleep_sync <= sleep_meta;
    end

    // ------------------------------------------------------------
    // Write channel handshake
    // ------------------------------------------------------------
    // Each half is taken once; no new half enters while the response waits
    assign s_axi_awready = (wr_state == WR_ACCEPT) && !aw_held;
    assign s_axi_wready  = (wr_state == WR_ACCEPT) && !w_held;

    // Transfers this edge
    assign aw_fire       = s_axi_awvalid && s_axi_awready;
    assign w_fire        = s_axi_wvalid && s_axi_wready;
    assign do_write      = (wr_state == WR_ACCEPT) && (aw_held || aw_fire) && (w_held || w_fire);

    // Pick captured halves over live ones
    // Bus may have moved on
    assign wr_addr = aw_held ? awaddr_q : s_axi_awaddr;
    assign wr_data = w_held ? wdata_q : s_axi_wdata;
    assign wr_strb = w_held ? wstrb_q : s_axi_wstrb;

    // Address decode of the write
    // Status writes are dropped
    assign wr_hit_low  = (wr_addr == byte_addr(IDX_RETAIN_LOW));
    assign wr_hit_high = (wr_addr == byte_addr(IDX_RETAIN_HIGH));
    assign wr_hit_stat = (wr_addr == byte_addr(IDX_STATUS));

    // Capture a half that arrives before its partner
    // Commit frees the channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held  <= 1'b0;
            w_held   <= 1'b0;
            awaddr_q <= '0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
        end else if (do_write) begin
            aw_held <= 1'b0;                 // Both consumed by the commit
            w_held  <= 1'b0;
        end else begin
            if (aw_fire) begin
                aw_held  <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_held  <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
        end
    end

    // Write response state and code
    // Stands until bready
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state     <= WR_ACCEPT;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            case (wr_state)
                WR_ACCEPT: begin
                    if (do_write) begin
                        wr_state     <= WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        // Status accepts writes silently; anything else unmapped errs
                        s_axi_bresp  <= (wr_hit_low || wr_hit_high || wr_hit_stat)
                                        ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                WR_RESP: begin
                    // Leave on bready
                    if (s_axi_bready) begin
                        wr_state     <= WR_ACCEPT;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    // Illegal code
                    wr_state     <= WR_ACCEPT;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Retention registers
    // ------------------------------------------------------------
    // Reset reloads the factory pattern of the strapped variant; the strap
    // must be stable for the two synchroniser cycles inside the reset pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_retain_ldo_low <= default_low(otp_sync);
            sleep_retain_ldo_high_and_converters <= default_high(otp_sync)
                                                    & HIGH_WRITE_MASK;
        end else if (do_write && wr_strb[0]) begin
            // Lane zero only
            if (wr_hit_low) begin
                sleep_retain_ldo_low <= wr_data[REG_W-1:0];
            end
            if (wr_hit_high) begin
                // Reserved bits never take a written one
                sleep_retain_ldo_high_and_converters <= wr_data[REG_W-1:0]
                                                        & HIGH_WRITE_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    // One read in flight
    assign s_axi_arready = (rd_state == RD_ACCEPT);
    assign ar_fire       = s_axi_arvalid && s_axi_arready;

    // Read mux; narrow data sits low and upper bits read zero
    // Status bit is synchronised
    always_comb begin
        next_rdata = '0;
        next_rresp = RESP_OKAY;
        if (s_axi_araddr == byte_addr(IDX_RETAIN_LOW)) begin
            next_rdata[REG_W-1:0] = sleep_retain_ldo_low;
        end else if (s_axi_araddr == byte_addr(IDX_RETAIN_HIGH)) begin
            next_rdata[REG_W-1:0] = sleep_retain_ldo_high_and_converters;
        end else if (s_axi_araddr == byte_addr(IDX_STATUS)) begin
            next_rdata[STATUS_ASLEEP] = sleep_sync;
        end else begin
            next_rresp = RESP_SLVERR;        // Unmapped address
        end
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state     <= RD_ACCEPT;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= RESP_OKAY;
        end else begin
            case (rd_state)
                RD_ACCEPT: begin
                    if (ar_fire) begin
                        // Latch with the address
                        rd_state     <= RD_RESP;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rdata  <= next_rdata;
                        s_axi_rresp  <= next_rresp;
                    end
                end
                RD_RESP: begin
                    // Leave on rready
                    if (s_axi_rready) begin
                        rd_state     <= RD_ACCEPT;
                        s_axi_rvalid <= 1'b0;
                    end
                end
                default: begin
                    // Illegal code
                    rd_state     <= RD_ACCEPT;
                    s_axi_rvalid <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Sleep mode decode
    // ------------------------------------------------------------
    // Bit order: regulators one to eight, then nine, ten, bucks one to four
    // Bits 7:6 carry no resource
    assign modes.retain  = {sleep_retain_ldo_high_and_converters[5:0],
                            sleep_retain_ldo_low};
    assign modes.turnoff = sleep_turnoff;
    assign modes.asleep  = sleep_sync;

    // Per-resource decode
    sleep_mode_decoder u_decoder (
        .modes (modes.decode)
    );

    // Registered so the power stages see glitch-free controls
    // Costs one cycle of latency
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_eco <= '0;
            res_off <= '0;
        end else begin
            // Follows decode by one edge
            res_eco <= modes.economy_low_power_mode;
            res_off <= modes.off;
        end
    end

endmodule : sleep_retention_control_regs

// >>> sim/sleep_retention_sva.sv
// Concurrent checker for the sleep retention register bank ports
`timescale 1ns/1ps
module sleep_retention_sva
    import sleep_retention_pkg::*;
(
    input wire logic                     aclk,           // Clock
    input wire logic                     aresetn,        // Sync reset, low
    input wire logic                     sleep_req,      // Sleep pin
    input wire logic                     s_axi_awvalid,  // Write address valid
    input wire logic                     s_axi_awready,  // Write address ready
    input wire logic                     s_axi_wvalid,   // Write data valid
    input wire logic                     s_axi_wready,   // Write data ready
    input wire logic                     s_axi_bvalid,   // Write response valid
    input wire logic [AXI_ADDR_W-1:0]    s_axi_araddr,   // Read address
    input wire logic                     s_axi_arvalid,  // Read address valid
    input wire logic                     s_axi_arready,  // Read address ready
    input wire logic [AXI_DATA_W-1:0]    s_axi_rdata,    // Read data
    input wire logic [1:0]               s_axi_rresp,    // Read response code
    input wire logic                     s_axi_rvalid,   // Read data valid
    input wire logic [NUM_RESOURCES-1:0] res_eco,        // Economy outputs
    input wire logic [NUM_RESOURCES-1:0] res_off         // Off outputs
);
    // ------------------------------------------------------------
    // Clocking and named steps
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Read of the high register accepted
    sequence s_ar_high;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'hA0;
    endsequence
    // Read of an address outside the map accepted
    sequence s_ar_unmapped;
        s_axi_arvalid && s_axi_arready && !(s_axi_araddr inside {8'h9C, 8'hA0, 8'hC0});
    endsequence
    // Both write halves taken at one edge
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // Sleep pin low long enough to pass the synchroniser and output flop
    sequence s_awake;
        !sleep_req [*3];
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_modes_exclusive: assert property ((res_eco & res_off) == '0)
        else $error("resource both in economy and off");
    a_awake_active: assert property (s_awake |=> res_eco == '0 && res_off == '0)
        else $error("resource left low power while awake");
    a_sleep_cause: assert property ((res_eco | res_off) != '0 |-> $past(sleep_req, 3))
        else $error("low power mode without sleep three edges earlier");
    a_high_reserved: assert property (s_ar_high |=> s_axi_rvalid && s_axi_rdata[31:6] == '0
        && s_axi_rresp == RESP_OKAY) else $error("high register reserved bits not zero");
    a_upper_zero: assert property (s_axi_rvalid && s_axi_rresp == RESP_OKAY
        |-> s_axi_rdata[31:8] == '0) else $error("read data upper bits not zero");
    a_unmapped_err: assert property (s_ar_unmapped |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR)
        else $error("unmapped read not refused");
    a_write_answer: assert property (s_wr_both |=> s_axi_bvalid && !s_axi_awready
        && !s_axi_wready) else $error("write response not one cycle after acceptance");
endmodule : sleep_retention_sva

bind sleep_retention_control_regs sleep_retention_sva u_sva (.*);

// >>> sim/tb_top.sv
// Self-checking testbench for the sleep retention register bank
`timescale 1ns/1ps
module tb_top;
    import sleep_retention_pkg::*;
    // ------------------------------------------------------------
    // Signals, counters and expected tables
    // ------------------------------------------------------------
    logic aclk = 0, aresetn = 0, sleep_req = 0;               // Clock, reset, sleep pin
    logic [1:0] otp_variant = 0, bresp, rresp;                // Variant strap, answers
    logic [13:0] sleep_turnoff = 0, res_eco, res_off;        // Turn-off in, modes out
    logic [7:0] awaddr = 0, araddr = 0;                      // Bus addresses
    logic [31:0] wdata = 0, rdata;                           // Bus data
    logic [3:0] wstrb = 0;                                   // Byte strobes
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0; // Master side
    logic awready, wready, bvalid, arready, rvalid;          // Slave side
    logic [7:0] exp_low [4] = '{8'hE6, 8'hE6, 8'h1A, 8'hFA}; // Factory low defaults
    logic [7:0] exp_high [4] = '{8'h3B, 8'h3B, 8'h12, 8'h1F}; // Factory high defaults
    localparam logic [7:0] A_LOW = 8'h9C, A_HIGH = 8'hA0, A_STAT = 8'hC0; // Byte addresses
    int num_errors = 0, tests_run = 0;                        // Verdict counters
    logic [31:0] d;                                           // Read result
    logic [1:0] r;                                            // Response result
    logic [13:0] keep;                                        // Retention pattern

    // Clock at 25 MHz
    initial begin
        forever #20 aclk = ~aclk;
    end

    sleep_retention_control_regs DUT (
        .aclk(aclk), .aresetn(aresetn), .otp_variant(otp_variant), .sleep_req(sleep_req),
        .sleep_turnoff(sleep_turnoff), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .res_eco(res_eco), .res_off(res_off));

    // ------------------------------------------------------------
    // Compare tasks, one per kind of result
    // ------------------------------------------------------------
    task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_data
    task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected response at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_resp
    task automatic check_mode(input logic [13:0] got, input logic [13:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected mode at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_mode

    // ------------------------------------------------------------
    // Bus tasks: hold each channel until its ready, answer ends the wait
    // ------------------------------------------------------------
    task automatic axi_write(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s,
                             output logic [1:0] resp);
        bit aw_done, w_done, got;
        aw_done = 0; w_done = 0; got = 0;
        @(posedge aclk);
        awaddr <= a; wdata <= v; wstrb <= s; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!got) begin
            @(posedge aclk);
            if (!aw_done && awready) begin aw_done = 1; awvalid <= 0; end
            if (!w_done && wready) begin w_done = 1; wvalid <= 0; end
            if (bvalid) begin got = 1; resp = bresp; bready <= 0; end
        end
    endtask : axi_write
    task automatic axi_read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        bit a_done, got;
        a_done = 0; got = 0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        while (!got) begin
            @(posedge aclk);
            if (!a_done && arready) begin a_done = 1; arvalid <= 0; end
            if (rvalid) begin got = 1; v = rdata; resp = rresp; rready <= 0; end
        end
    endtask : axi_read

    // Apply reset for 20 cycles with a stable variant strap
    task automatic do_reset(input logic [1:0] v);
        @(posedge aclk);
        aresetn <= 0; otp_variant <= v;
        repeat (20) @(posedge aclk);
        aresetn <= 1;
    endtask : do_reset

    // Enter sleep with the given turn-off pattern and check each resource
    task automatic sleep_check(input logic [13:0] toff);
        sleep_turnoff <= toff; sleep_req <= 1;
        repeat (6) @(posedge aclk);
        check_mode(res_eco, ~keep & ~toff);
        check_mode(res_off, ~keep & toff);
        axi_read(A_STAT, d, r);
        check_data(d, 32'h1);
        sleep_req <= 0;
        repeat (6) @(posedge aclk);
        check_mode(res_eco | res_off, 14'h0);
    endtask : sleep_check

    // Closing verdict
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results

    // Watchdog: tests take a few hundred cycles
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        results();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        for (int v = 0; v < 4; v++) begin
            do_reset(v[1:0]);
            axi_read(A_LOW, d, r);  check_data(d, {24'h0, exp_low[v]});
            axi_read(A_HIGH, d, r); check_data(d, {24'h0, exp_high[v]});
            axi_write(A_LOW, 32'hFFFF_FF5A, 4'hF, r); check_resp(r, RESP_OKAY);
            axi_write(A_HIGH, 32'h0000_00FF, 4'hF, r);
            axi_read(A_LOW, d, r);  check_data(d, 32'h0000_005A);
            axi_read(A_HIGH, d, r); check_data(d, 32'h0000_003F);
            $display("variant %0d defaults and write-back done", v);
        end
        do_reset(2'h0);
        axi_read(A_LOW, d, r);  check_data(d, 32'h0000_00E6);
        axi_read(A_HIGH, d, r); check_data(d, 32'h0000_003B);
        axi_write(8'h00, 32'h0000_0000, 4'hF, r); check_resp(r, RESP_SLVERR);
        axi_read(8'hFC, d, r);  check_resp(r, RESP_SLVERR);
        axi_write(A_LOW, 32'h0000_0000, 4'hE, r); check_resp(r, RESP_OKAY);
        axi_read(A_LOW, d, r);  check_data(d, 32'h0000_00E6);
        $display("map and refusal test done");
        axi_write(A_LOW, 32'h0000_000F, 4'h1, r);
        axi_write(A_HIGH, 32'h0000_0025, 4'h1, r);
        keep = 14'h250F;
        sleep_check(14'h00F0);
        sleep_check(14'h3FFF);
        $display("sleep mode test done");
        results();
    end
endmodule : tb_top
